/* File: rtl/dsa_pkg.sv */
// constants and types for the data-space access unit
// assumes a single core clock and a synchronous active-high reset
package dsa_pkg;
  localparam int ADDR_W = 16; // effective address width in bits
  localparam int PAGE_W = 8; // page select width, 8+16 = 24 bits = 16 Mbytes
  localparam int XA_W = 24; // extended address width
  localparam int DATA_W = 16; // word width
  localparam int BYTE_W = 8; // lane width
  localparam int RAM_WORDS = 256; // implemented ram words in this build
  localparam int RAM_AW = 8; // word index width of the ram array
  localparam int REGF_WORDS = 16; // implemented peripheral register words
  localparam int REGF_AW = 4; // word index width of the register array
  localparam logic [ADDR_W-1:0] PERIPH_LO = 16'h0000; // peripheral region start
  localparam logic [ADDR_W-1:0] PERIPH_HI = 16'h0FFF; // peripheral region end
  localparam logic [ADDR_W-1:0] NEAR_HI = 16'h1FFF; // near region end
  localparam logic [ADDR_W-1:0] RAM_LO = 16'h1000; // ram start
  localparam logic [ADDR_W-1:0] RAM_HI = 16'hCFFF; // ram end, 48 Kbytes max
  localparam int NEAR_AF_W = 13; // near absolute field width
  localparam logic [ADDR_W-1:0] STEP_BYTE = 16'h0001; // pointer step, byte op
  localparam logic [ADDR_W-1:0] STEP_WORD = 16'h0002; // pointer step, word op
  localparam logic [PAGE_W-1:0] PAGE_RST = 8'h00; // page select reset value
  localparam logic [DATA_W-1:0] ZERO_W = 16'h0000; // unimplemented read value
  // working register operations
  typedef enum logic [1:0] {DSA_WOP_NONE, DSA_WOP_SEXT, DSA_WOP_UCLR} dsa_wop_t;
endpackage

/* File: rtl/dsa_unit.sv */
// data-space access unit: read and write paths, lanes, page extension, traps
// assumes the core holds request inputs stable for one cycle per access
`timescale 1ns/1ps
// Notes on behaviour
// - separate read and write address paths
// - sixteen-bit byte effective addresses, 64 Kbytes
// - page select extends reads and writes
// - unimplemented locations read as zero
// - low byte even, high byte odd
// - pointer post-step one byte, two word
// - byte read selects lane, lands low
// - two lanes, byte write hits one
// - odd word access raises address trap
// - misaligned write suppressed, trap afterward
// - byte load keeps register high byte
// - sign extend eight bits to sixteen
// - upper clear zeroes high byte
// - peripheral region 0x0000 to 0x0FFF
// - unused peripheral addresses read zero
// - near region via 13-bit field
// - whole space via direct or pointer
module dsa_unit (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // read path from the read address generator
  input wire logic i_rd_req,
  input wire logic i_rd_byte,
  input wire logic i_rd_near,
  input wire logic i_rd_ptr,
  input wire logic [dsa_pkg::ADDR_W-1:0] i_rd_effective_address,
  // write path from the write address generator
  input wire logic i_wr_req,
  input wire logic i_wr_byte,
  input wire logic i_wr_near,
  input wire logic i_wr_ptr,
  input wire logic [dsa_pkg::ADDR_W-1:0] i_wr_effective_address,
  input wire logic [dsa_pkg::DATA_W-1:0] i_wr_data,
  // page selects
  input wire logic i_rpage_we,
  input wire logic i_wpage_we,
  input wire logic [dsa_pkg::PAGE_W-1:0] i_page_data,
  // working register operation
  input wire dsa_pkg::dsa_wop_t i_wop,
  input wire logic [dsa_pkg::DATA_W-1:0] i_wreg,
  // read answer
  output logic o_rd_valid,
  output logic [dsa_pkg::DATA_W-1:0] o_rd_data,
  output logic [dsa_pkg::DATA_W-1:0] o_rd_load,
  output logic [dsa_pkg::XA_W-1:0] o_rd_xaddr,
  output logic [dsa_pkg::ADDR_W-1:0] o_rd_ptr_nxt,
  output logic o_rd_periph,
  output logic o_rd_nearreg,
  // write answer
  output logic o_wr_done,
  output logic [1:0] o_wr_lane_en,
  output logic [dsa_pkg::XA_W-1:0] o_wr_xaddr,
  output logic [dsa_pkg::ADDR_W-1:0] o_wr_ptr_nxt,
  // working register result and trap
  output logic [dsa_pkg::DATA_W-1:0] o_wop_res,
  output logic o_addr_trap,
  // page select readback
  output logic [dsa_pkg::PAGE_W-1:0] o_rpage,
  output logic [dsa_pkg::PAGE_W-1:0] o_wpage
);
  import dsa_pkg::*;

  // region decode, shared by both paths
  function automatic logic in_periph(input logic [ADDR_W-1:0] a);
    in_periph = (a >= PERIPH_LO) && (a <= PERIPH_HI);
  endfunction
  function automatic logic in_ram(input logic [ADDR_W-1:0] a);
    in_ram = (a >= RAM_LO) && (a <= RAM_HI);
  endfunction
  function automatic logic in_near(input logic [ADDR_W-1:0] a);
    in_near = (a <= NEAR_HI);
  endfunction
  // peripheral word implemented in the register array
  function automatic logic periph_hit(input logic [ADDR_W-1:0] a);
    periph_hit = in_periph(a) && (a[ADDR_W-1:REGF_AW+1] == '0);
  endfunction
  // ram word implemented in the ram array
  function automatic logic ram_hit(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - RAM_LO;
    ram_hit = in_ram(a) && (off[ADDR_W-1:RAM_AW+1] == '0);
  endfunction
  // post-step of a pointer by access size
  function automatic logic [ADDR_W-1:0] step(input logic [ADDR_W-1:0] a, input logic b);
    step = a + (b ? STEP_BYTE : STEP_WORD);
  endfunction

  // storage: two byte lanes per word, one decode per word
  logic [BYTE_W-1:0] ram_lo [RAM_WORDS]; // even-address bytes
  logic [BYTE_W-1:0] ram_hi [RAM_WORDS]; // odd-address bytes
  logic [BYTE_W-1:0] reg_lo [REGF_WORDS];
  logic [BYTE_W-1:0] reg_hi [REGF_WORDS];
  logic [PAGE_W-1:0] rpage_ff; // read page select
  logic [PAGE_W-1:0] wpage_ff; // write page select

  // combinational decode of the current requests
  logic rd_mis; // odd word read
  logic wr_mis; // odd word write
  logic rd_legal; // near-field reads must stay in the near region
  logic wr_legal;
  logic [1:0] nxt_lane; // byte-lane write enables
  logic [RAM_AW-1:0] rd_ri;
  logic [RAM_AW-1:0] wr_ri;
  logic [ADDR_W-1:0] rd_addr; // read effective address
  logic [ADDR_W-1:0] wr_addr; // write effective address
  logic [ADDR_W-1:0] rd_off;
  logic [ADDR_W-1:0] wr_off;
  logic [DATA_W-1:0] rd_word; // whole containing word
  logic [BYTE_W-1:0] rd_sel; // byte picked by address bit zero
  logic [DATA_W-1:0] nxt_rd_data;

  assign rd_addr = i_rd_effective_address;
  assign wr_addr = i_wr_effective_address;
  assign rd_mis = i_rd_req && !i_rd_byte && rd_addr[0];
  assign wr_mis = i_wr_req && !i_wr_byte && wr_addr[0];
  // a 13-bit field only reaches the near region; others use all 16 bits
  assign rd_legal = !i_rd_near || (rd_addr[ADDR_W-1:NEAR_AF_W] == '0);
  assign wr_legal = !i_wr_near || (wr_addr[ADDR_W-1:NEAR_AF_W] == '0);
  assign rd_off = rd_addr - RAM_LO;
  assign wr_off = wr_addr - RAM_LO;
  assign rd_ri = rd_off[RAM_AW:1];
  assign wr_ri = wr_off[RAM_AW:1];

  // lane enables: both for aligned word, one for byte, none if suppressed
  always_comb begin
    nxt_lane = 2'h0;
    if (i_wr_req && wr_legal && !wr_mis) begin
      if (!i_wr_byte) begin
        nxt_lane = 2'h3;
      end else begin
        nxt_lane = wr_addr[0] ? 2'h2 : 2'h1;
      end
    end
  end

  // read the whole word; unimplemented and unused locations give zero
  always_comb begin
    rd_word = ZERO_W;
    if (ram_hit(rd_addr)) begin
      rd_word = {ram_hi[rd_ri], ram_lo[rd_ri]};
    end else if (periph_hit(rd_addr)) begin
      rd_word = {reg_hi[rd_addr[REGF_AW:1]], reg_lo[rd_addr[REGF_AW:1]]};
    end
    if (!rd_legal) begin
      rd_word = ZERO_W;
    end
    rd_sel = rd_addr[0] ? rd_word[DATA_W-1:BYTE_W] : rd_word[BYTE_W-1:0];
    nxt_rd_data = i_rd_byte ? {{BYTE_W{1'b0}}, rd_sel} : rd_word;
  end

  // page select registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rpage_ff <= PAGE_RST;
      wpage_ff <= PAGE_RST;
    end else begin
      if (i_rpage_we) begin
        rpage_ff <= i_page_data;
      end
      if (i_wpage_we) begin
        wpage_ff <= i_page_data;
      end
    end
  end

  // ram writes, per lane; contents are not reset, as real ram is not
  always_ff @(posedge i_clk) begin
    if (nxt_lane[0] && ram_hit(wr_addr)) begin
      ram_lo[wr_ri] <= i_wr_data[BYTE_W-1:0];
    end
    if (nxt_lane[1] && ram_hit(wr_addr)) begin
      ram_hi[wr_ri] <= i_wr_byte ? i_wr_data[BYTE_W-1:0] : i_wr_data[DATA_W-1:BYTE_W];
    end
  end

  // peripheral register writes, per lane; cleared by reset so that a
  // register read before its first write gives zero, not unknowns
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int k = 0; k < REGF_WORDS; k++) begin
        reg_lo[k] <= '0;
        reg_hi[k] <= '0;
      end
    end else begin
      if (nxt_lane[0] && periph_hit(wr_addr)) begin
        reg_lo[wr_addr[REGF_AW:1]] <= i_wr_data[BYTE_W-1:0];
      end
      if (nxt_lane[1] && periph_hit(wr_addr)) begin
        reg_hi[wr_addr[REGF_AW:1]] <= i_wr_byte ? i_wr_data[BYTE_W-1:0]
                                                : i_wr_data[DATA_W-1:BYTE_W];
      end
    end
  end

  // read path outputs; a misaligned read still completes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= ZERO_W;
      o_rd_load <= ZERO_W;
      o_rd_xaddr <= '0;
      o_rd_ptr_nxt <= '0;
      o_rd_periph <= 1'b0;
      o_rd_nearreg <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_req;
      if (i_rd_req) begin
        o_rd_data <= nxt_rd_data;
        // byte load merges into the register low byte only
        o_rd_load <= i_rd_byte ? {i_wreg[DATA_W-1:BYTE_W], rd_sel} : rd_word;
        o_rd_xaddr <= {rpage_ff, rd_addr};
        o_rd_ptr_nxt <= i_rd_ptr ? step(rd_addr, i_rd_byte) : rd_addr;
        o_rd_periph <= in_periph(rd_addr);
        o_rd_nearreg <= in_near(rd_addr);
      end
    end
  end

  // write path outputs; lane enables report what was written
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_wr_done <= 1'b0;
      o_wr_lane_en <= 2'h0;
      o_wr_xaddr <= '0;
      o_wr_ptr_nxt <= '0;
    end else begin
      o_wr_done <= i_wr_req;
      o_wr_lane_en <= nxt_lane;
      if (i_wr_req) begin
        o_wr_xaddr <= {wpage_ff, wr_addr};
        o_wr_ptr_nxt <= i_wr_ptr ? step(wr_addr, i_wr_byte) : wr_addr;
      end
    end
  end

  // trap pulse one cycle after the access, so the instruction completes first
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_addr_trap <= 1'b0;
    end else begin
      o_addr_trap <= rd_mis || wr_mis;
    end
  end

  // working register operations
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_wop_res <= ZERO_W;
    end else begin
      case (i_wop)
        DSA_WOP_SEXT: o_wop_res <= {{BYTE_W{i_wreg[BYTE_W-1]}}, i_wreg[BYTE_W-1:0]};
        DSA_WOP_UCLR: o_wop_res <= {{BYTE_W{1'b0}}, i_wreg[BYTE_W-1:0]};
        DSA_WOP_NONE: o_wop_res <= i_wreg;
        default: o_wop_res <= i_wreg;
      endcase
    end
  end

  // page readback
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rpage <= PAGE_RST;
      o_wpage <= PAGE_RST;
    end else begin
      o_rpage <= rpage_ff;
      o_wpage <= wpage_ff;
    end
  end

  // checks
  sequence s_odd_word_wr;
    i_wr_req && !i_wr_byte && wr_addr[0];
  endsequence
  property p_trap_on_odd;
    @(posedge i_clk) disable iff (i_rst)
      (i_rd_req && !i_rd_byte && rd_addr[0]) |=> o_addr_trap;
  endproperty
  a_trap_on_odd: assert property (p_trap_on_odd) else $error("no trap on odd read");
  property p_wr_suppr;
    @(posedge i_clk) disable iff (i_rst)
      s_odd_word_wr |=> (o_wr_lane_en == 2'h0) && o_addr_trap && o_wr_done;
  endproperty
  a_wr_suppr: assert property (p_wr_suppr) else $error("odd write not suppressed");
  property p_word_lanes;
    @(posedge i_clk) disable iff (i_rst)
      (i_wr_req && !i_wr_byte && !wr_addr[0] && !i_wr_near) |=> o_wr_lane_en == 2'h3;
  endproperty
  a_word_lanes: assert property (p_word_lanes) else $error("word write lanes wrong");
  property p_byte_lane;
    @(posedge i_clk) disable iff (i_rst)
      (i_wr_req && i_wr_byte && !i_wr_near) |=> o_wr_lane_en == ($past(wr_addr[0]) ? 2'h2 : 2'h1);
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("byte lane wrong");
  property p_step;
    @(posedge i_clk) disable iff (i_rst)
      (i_rd_req && i_rd_ptr) |=>
        o_rd_ptr_nxt == $past(rd_addr) + ($past(i_rd_byte) ? 16'h0001 : 16'h0002);
  endproperty
  a_step: assert property (p_step) else $error("pointer step wrong");
  property p_unimpl_zero;
    @(posedge i_clk) disable iff (i_rst)
      (i_rd_req && rd_addr > RAM_HI) |=> o_rd_data == ZERO_W;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented read nonzero");
  property p_byte_hi_zero;
    @(posedge i_clk) disable iff (i_rst)
      (i_rd_req && i_rd_byte) |=> o_rd_data[15:8] == 8'h00;
  endproperty
  a_byte_hi_zero: assert property (p_byte_hi_zero) else $error("byte read high not zero");
  property p_load_keep;
    @(posedge i_clk) disable iff (i_rst)
      (i_rd_req && i_rd_byte) |=> o_rd_load[15:8] == $past(i_wreg[15:8]);
  endproperty
  a_load_keep: assert property (p_load_keep) else $error("byte load changed high");
  property p_sext;
    @(posedge i_clk) disable iff (i_rst)
      (i_wop == DSA_WOP_SEXT) |=> $signed(o_wop_res) == $signed($past(i_wreg[7:0]));
  endproperty
  a_sext: assert property (p_sext) else $error("sign extend wrong");
  property p_xaddr;
    @(posedge i_clk) disable iff (i_rst)
      i_wr_req |=> o_wr_xaddr == {$past(wpage_ff), $past(wr_addr)};
  endproperty
  a_xaddr: assert property (p_xaddr) else $error("write extended address wrong");
endmodule

/* File: sim/dsa_core_model.sv */
// core address generator model: drives the read and write request paths
// assumes one access per call, launched on a rising edge, one cycle long
`timescale 1ns/1ps
module dsa_core_model (
  // clock
  input wire logic i_clk,
  // read path
  output logic o_rd_req,
  output logic o_rd_byte,
  output logic o_rd_near,
  output logic o_rd_ptr,
  output logic [dsa_pkg::ADDR_W-1:0] o_rd_effective_address,
  // write path
  output logic o_wr_req,
  output logic o_wr_byte,
  output logic o_wr_near,
  output logic o_wr_ptr,
  output logic [dsa_pkg::ADDR_W-1:0] o_wr_effective_address,
  output logic [dsa_pkg::DATA_W-1:0] o_wr_data
);
  import dsa_pkg::*;
  initial begin
    {o_rd_req, o_rd_byte, o_rd_near, o_rd_ptr, o_rd_effective_address} = '0;
    {o_wr_req, o_wr_byte, o_wr_near, o_wr_ptr, o_wr_effective_address, o_wr_data} = '0;
  end
  // one access; released fields show the inverse so stale values never match
  task automatic acc(input bit wr, by, nr, pt, input logic [15:0] adr, d);
    @(posedge i_clk);
    if (wr) begin
      {o_wr_req, o_wr_byte, o_wr_near, o_wr_ptr} <= {1'b1, by, nr, pt};
      o_wr_effective_address <= adr;
      o_wr_data <= d;
      @(posedge i_clk);
      o_wr_req <= 1'b0;
      o_wr_effective_address <= ~adr;
      o_wr_data <= ~d;
    end else begin
      {o_rd_req, o_rd_byte, o_rd_near, o_rd_ptr} <= {1'b1, by, nr, pt};
      o_rd_effective_address <= adr;
      @(posedge i_clk);
      o_rd_req <= 1'b0;
      o_rd_effective_address <= ~adr;
    end
  endtask
endmodule

/* File: sim/data_space_access_unit_test.sv */
// self-checking bench for the data-space access unit
// assumes the core model in dsa_core_model drives both request paths
`timescale 1ns/1ps
module data_space_access_unit_test;
  import dsa_pkg::*;
  logic i_clk = 0, i_rst = 1, i_rpage_we = 0, i_wpage_we = 0;
  logic rq, rb, rn, rp, wq, wb, wn, wp;
  logic [15:0] rea, wea, wd, i_wreg = '0;
  logic [7:0] i_page_data = '0, rpg, wpg;
  dsa_wop_t i_wop = DSA_WOP_NONE;
  logic o_rd_valid, o_rd_periph, o_rd_nearreg, o_wr_done, o_addr_trap;
  logic [15:0] o_rd_data, o_rd_load, o_rd_ptr_nxt, o_wr_ptr_nxt, o_wop_res;
  logic [23:0] o_rd_xaddr, o_wr_xaddr;
  logic [1:0] o_wr_lane_en;
  logic [7:0] o_rpage, o_wpage;
  logic [15:0] mem [int]; // model memory, word index
  int err_total = 0, tests_run = 0;
  dsa_core_model u_core (.i_clk, .o_rd_req(rq), .o_rd_byte(rb), .o_rd_near(rn),
    .o_rd_ptr(rp), .o_rd_effective_address(rea), .o_wr_req(wq), .o_wr_byte(wb),
    .o_wr_near(wn), .o_wr_ptr(wp), .o_wr_effective_address(wea), .o_wr_data(wd));
  dsa_unit u_dut (.i_clk, .i_rst, .i_rd_req(rq), .i_rd_byte(rb), .i_rd_near(rn),
    .i_rd_ptr(rp), .i_rd_effective_address(rea), .i_wr_req(wq), .i_wr_byte(wb),
    .i_wr_near(wn), .i_wr_ptr(wp), .i_wr_effective_address(wea), .i_wr_data(wd),
    .i_rpage_we, .i_wpage_we,
    .i_page_data, .i_wop, .i_wreg, .o_rd_valid, .o_rd_data, .o_rd_load,
    .o_rd_xaddr, .o_rd_ptr_nxt, .o_rd_periph, .o_rd_nearreg, .o_wr_done,
    .o_wr_lane_en, .o_wr_xaddr, .o_wr_ptr_nxt, .o_wop_res, .o_addr_trap,
    .o_rpage, .o_wpage);
  // 100 MHz core clock
  initial forever #5 i_clk = ~i_clk;
  task automatic chk(input string n, input logic [23:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // load both page selects and check the readback
  task automatic pages();
    rpg = $urandom;
    wpg = $urandom;
    @(posedge i_clk);
    {i_rpage_we, i_page_data} <= {1'b1, rpg};
    @(posedge i_clk);
    {i_rpage_we, i_wpage_we, i_page_data} <= {2'b01, wpg};
    @(posedge i_clk);
    i_wpage_we <= 1'b0;
    // readback trails the page register by one more edge
    @(posedge i_clk);
    #1;
    chk("rpage", o_rpage, rpg);
    chk("wpage", o_wpage, wpg);
  endtask
  // one access through the core model, compared with the model memory
  task automatic go(input bit wr, by, nr, pt, input logic [15:0] adr, d);
    logic [15:0] w, b;
    bit odd, imp, ill;
    odd = adr[0] && !by; // misaligned word
    ill = nr && adr[15:13] != 0; // near field cannot reach this address
    imp = !ill && ((adr >= 16'h1000 && adr <= 16'h11FF) || adr <= 16'h001F);
    w = (imp && mem.exists(adr >> 1)) ? mem[adr >> 1] : ZERO_W;
    b = adr[0] ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
    u_core.acc(wr, by, nr, pt, adr, d);
    #1;
    if (wr) begin
      chk("done", o_wr_done, 1);
      chk("lane", o_wr_lane_en, (odd || ill) ? 0 : by ? (adr[0] ? 2 : 1) : 3);
      chk("wxa", o_wr_xaddr, {wpg, adr});
      chk("wptr", o_wr_ptr_nxt, pt ? adr + (by ? 1 : 2) : adr);
      if (!odd && imp) begin
        if (!by) mem[adr >> 1] = d;
        else if (adr[0]) mem[adr >> 1] = {d[7:0], w[7:0]};
        else mem[adr >> 1] = {w[15:8], d[7:0]};
      end
    end else begin
      chk("valid", o_rd_valid, 1);
      chk("rdat", o_rd_data, by ? b : w);
      chk("load", o_rd_load, by ? {i_wreg[15:8], b[7:0]} : w);
      chk("rxa", o_rd_xaddr, {rpg, adr});
      chk("rptr", o_rd_ptr_nxt, pt ? adr + (by ? 1 : 2) : adr);
      chk("periph", o_rd_periph, adr <= 16'h0FFF);
      chk("near", o_rd_nearreg, adr <= 16'h1FFF);
    end
    chk("trap", o_addr_trap, odd);
  endtask
  // watchdog, well above the two hundred or so cycles the tests need
  initial begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    report_and_stop();
  end
  initial begin
    void'($urandom(22));
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    pages();
    for (int k = 0; k < 8; k++) go(1, 0, 0, k[0], 16'h1000 + 2 * k, $urandom);
    @(posedge i_clk);
    i_wreg <= $urandom;
    for (int k = 0; k < 4; k++) go(0, 1, 0, 1, 16'h1000 + k, 0);
    go(1, 1, 0, 1, 16'h1003, $urandom);
    go(1, 1, 0, 0, 16'h1004, $urandom);
    go(0, 0, 0, 0, 16'h1002, 0);
    go(0, 0, 0, 0, 16'h1004, 0);
    go(1, 0, 0, 1, 16'h1007, $urandom);
    go(0, 0, 0, 0, 16'h1006, 0);
    go(0, 0, 0, 1, 16'h1009, 0);
    go(0, 1, 0, 0, 16'hE000, 0);
    go(0, 1, 0, 0, 16'h0800, 0);
    go(0, 1, 0, 0, 16'h1800, 0);
    go(0, 1, 0, 0, 16'h0000, 0);
    go(1, 0, 0, 0, 16'h0010, $urandom);
    go(0, 0, 0, 0, 16'h0010, 0);
    go(1, 1, 0, 0, 16'h0013, $urandom);
    go(0, 0, 0, 0, 16'h0012, 0);
    go(0, 0, 1, 0, 16'h2000, 0);
    go(1, 0, 1, 0, 16'h2010, $urandom);
    pages();
    fork
      go(1, 0, 0, 1, 16'h100E, $urandom);
      go(0, 0, 0, 1, 16'h1000, 0);
    join
    repeat (40) go($urandom % 2, $urandom % 2, 0, $urandom % 2,
      16'h1000 + ($urandom % 16), $urandom);
    for (int k = 0; k < 6; k++) begin
      @(posedge i_clk);
      i_wop <= (k % 3 == 0) ? DSA_WOP_SEXT : (k % 3 == 1) ? DSA_WOP_UCLR : DSA_WOP_NONE;
      i_wreg <= $urandom;
      @(posedge i_clk);
      @(posedge i_clk);
      #1;
      if (k % 3 == 0) chk("sext", o_wop_res, {{8{i_wreg[7]}}, i_wreg[7:0]});
      else if (k % 3 == 1) chk("uclr", o_wop_res, {8'h00, i_wreg[7:0]});
      else chk("wreg", o_wop_res, i_wreg);
    end
    report_and_stop();
  end
endmodule
